//--- irq_regs_pkg.sv
// Purpose: Constants for the interrupt flag, enable and priority register block
// Assumes: Wishbone classic slave, 32-bit data, byte address on wb_adr_i
// Notes: Word offsets are byte addresses on four-byte boundaries
package irq_regs_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned SRC_COUNT = 32;
  localparam int unsigned PRIO_REGS = 8;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned EVT_W = 2;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ENABLES = 8'h04;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVT_MASK = 8'h0c;
  localparam logic [7:0] OFS_PENDING = 8'h10;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h20;
  localparam logic [2:0] PRIO_WIN = 3'h1;
  // ==========================================================
  // Field layout of one priority byte
  localparam int unsigned PRIO_LSB = 2;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned SUB_LSB = 0;
  localparam int unsigned SUB_W = 2;
  localparam logic [31:0] PRIO_IMPL_MASK = 32'h1f1f1f1f;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  // ==========================================================
  // Event status bits
  localparam int unsigned EVT_REQ = 0;
  localparam int unsigned EVT_BADADR = 1;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [1:0] RST_EVT = 2'h0;
endpackage : irq_regs_pkg

//--- irq_flag_enable_priority_regs.sv
// Purpose: Interrupt request flags, enables and per-source priority registers
// Assumes: Single clock, synchronous active-low reset, req_i synchronous pulses or levels
// Notes: Registers answer on Wishbone classic with a registered one-cycle ack, one cycle after the strobe
`timescale 1ns/1ps

module irq_flag_enable_priority_regs
  import irq_regs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] req_i,
  output logic [31:0] pending_o,
  output logic irq_o
);

  // ==========================================================
  // State
  logic [31:0] flags;
  logic [31:0] enables;
  logic [31:0] prio [PRIO_REGS];
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic [31:0] next_flags;
  logic [31:0] next_enables;
  logic [31:0] next_prio [PRIO_REGS];
  logic [1:0] next_evt_status;
  logic [1:0] next_evt_mask;
  logic [31:0] next_pending;
  logic next_irq;
  logic next_ack;
  logic [31:0] next_rdat;
  logic [31:0] prio_nz;
  logic access;
  logic wr;
  logic hit_prio;
  logic [2:0] prio_idx;
  logic mapped;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================
  // Priority nonzero per source
  genvar g;
  generate
    for (g = 0; g < SRC_COUNT; g++) begin : g_nz
      assign prio_nz[g] = prio[g / 4][8 * (g % 4) + PRIO_LSB +: PRIO_W] != PRIO_OFF;
    end
  endgenerate

  // ==========================================================
  // Bus decode
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i;
  assign hit_prio = wb_adr_i[7:5] == PRIO_WIN;
  assign prio_idx = wb_adr_i[4:2];
  assign mapped = hit_prio || wb_adr_i == OFS_FLAGS || wb_adr_i == OFS_ENABLES ||
                  wb_adr_i == OFS_EVT_STATUS || wb_adr_i == OFS_EVT_MASK ||
                  wb_adr_i == OFS_PENDING;

  // ==========================================================
  // Next values
  always_comb begin
    next_flags = flags;
    next_enables = enables;
    for (int i = 0; i < PRIO_REGS; i++) begin
      next_prio[i] = prio[i];
    end
    next_evt_status = evt_status;
    next_evt_mask = evt_mask;
    next_rdat = RST_WORD;
    next_ack = access;
    if (wr && wb_adr_i == OFS_FLAGS) begin
      next_flags = merge(flags, wb_dat_i, wb_sel_i);
    end
    next_flags = next_flags | req_i;
    if (wr && wb_adr_i == OFS_ENABLES) begin
      next_enables = merge(enables, wb_dat_i, wb_sel_i);
    end
    if (wr && hit_prio) begin
      next_prio[prio_idx] = merge(prio[prio_idx], wb_dat_i & PRIO_IMPL_MASK,
                                  wb_sel_i);
    end
    if (wr && wb_adr_i == OFS_EVT_MASK && wb_sel_i[0]) begin
      next_evt_mask = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == OFS_EVT_STATUS && wb_sel_i[0]) begin
      next_evt_status = evt_status & ~wb_dat_i[1:0];
    end
    if (|req_i) begin
      next_evt_status[EVT_REQ] = 1'b1;
    end
    if (access && !mapped) begin
      next_evt_status[EVT_BADADR] = 1'b1;
    end
    if (access && !wb_we_i) begin
      if (hit_prio) begin
        next_rdat = prio[prio_idx] & PRIO_IMPL_MASK;
      end else begin
        case (wb_adr_i)
          OFS_FLAGS: next_rdat = flags;
          OFS_ENABLES: next_rdat = enables;
          OFS_EVT_STATUS: next_rdat = {30'h0, evt_status};
          OFS_EVT_MASK: next_rdat = {30'h0, evt_mask};
          OFS_PENDING: next_rdat = pending_o;
          default: next_rdat = RST_WORD;
        endcase
      end
    end
    next_pending = flags & enables & prio_nz;
    next_irq = |(next_evt_status & next_evt_mask);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flags <= RST_WORD;
      enables <= RST_WORD;
      for (int i = 0; i < PRIO_REGS; i++) begin
        prio[i] <= RST_WORD;
      end
      evt_status <= RST_EVT;
      evt_mask <= RST_EVT;
      pending_o <= RST_WORD;
      irq_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      for (int i = 0; i < PRIO_REGS; i++) begin
        prio[i] <= next_prio[i];
      end
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      pending_o <= next_pending;
      irq_o <= next_irq;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
    end
  end

  // ==========================================================
  // Checks
  property p_flag_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (|req_i) |=> ((flags & $past(req_i)) == $past(req_i));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request did not set flag");

  property p_flag_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && wb_adr_i == OFS_FLAGS && wb_sel_i == 4'hf && req_i == 32'h0)
      |=> (flags == $past(wb_dat_i));
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write lost");

  property p_enable_gate;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ##1 ((pending_o & ~$past(enables)) == 32'h0);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("disabled source pending");

  property p_enable_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && wb_adr_i == OFS_ENABLES && wb_sel_i == 4'hf) |=> (enables == $past(wb_dat_i));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_prio_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && hit_prio && wb_sel_i == 4'hf)
      |=> (prio[$past(prio_idx)] == ($past(wb_dat_i) & PRIO_IMPL_MASK));
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write wrong");

  property p_prio_unimpl;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ($past(access) && !$past(wb_we_i) && $past(hit_prio))
      |-> ((wb_dat_o & ~PRIO_IMPL_MASK) == 32'h0);
  endproperty
  a_prio_unimpl: assert property (p_prio_unimpl) else $error("unimplemented bits read 1");

  property p_prio_zero;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ##1 ((pending_o & ~$past(prio_nz)) == 32'h0);
  endproperty
  a_prio_zero: assert property (p_prio_zero) else $error("zero priority pending");

  property p_sub_keep;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && hit_prio && wb_sel_i[0]) |=> (prio[$past(prio_idx)][1:0] == $past(wb_dat_i[1:0]));
  endproperty
  a_sub_keep: assert property (p_sub_keep) else $error("subpriority not stored");

  property p_forward;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ##1 (pending_o == ($past(flags) & $past(enables) & $past(prio_nz)));
  endproperty
  a_forward: assert property (p_forward) else $error("forwarded set wrong");

  // ==========================================================
  // Whole priority bank for bank-wide checks
  logic [32*PRIO_REGS-1:0] prio_flat;
  genvar h;
  generate
    for (h = 0; h < PRIO_REGS; h++) begin : g_flat
      assign prio_flat[32*h +: 32] = prio[h];
    end
  endgenerate

  property p_flag_reset;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> (flags == RST_WORD);
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flags not cleared by reset");

  property p_enable_reset;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> (enables == RST_WORD);
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enables not cleared");

  property p_prio_reset;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !$past(nrst_i) |-> (prio_flat == {PRIO_REGS{RST_WORD}});
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priorities not cleared");

  property p_flag_sticky;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !(wr && wb_adr_i == OFS_FLAGS) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");

  property p_enable_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !(wr && wb_adr_i == OFS_ENABLES) |=> $stable(enables);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enables changed unasked");

  property p_prio_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !(wr && hit_prio) |=> $stable(prio_flat);
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("priorities changed unasked");

  property p_unimpl_zero;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (prio_flat & ~{PRIO_REGS{PRIO_IMPL_MASK}}) == {PRIO_REGS{RST_WORD}};
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits stored");

  property p_prio_field;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && hit_prio && wb_sel_i[3])
      |=> (prio[$past(prio_idx)][28:26] == $past(wb_dat_i[28:26]));
  endproperty
  a_prio_field: assert property (p_prio_field) else $error("priority field not stored");

  property p_sub_field;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr && hit_prio && wb_sel_i[3])
      |=> (prio[$past(prio_idx)][25:24] == $past(wb_dat_i[25:24]));
  endproperty
  a_sub_field: assert property (p_sub_field) else $error("subpriority field not stored");

  property p_flag_read;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (access && !wb_we_i && wb_adr_i == OFS_FLAGS) |=> (wb_dat_o == $past(flags));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

  property p_enable_read;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (access && !wb_we_i && wb_adr_i == OFS_ENABLES) |=> (wb_dat_o == $past(enables));
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

  property p_ack_answer;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      access |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("access not acknowledged");

  property p_ack_pulse;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_rdat_idle;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !wb_ack_o |-> (wb_dat_o == RST_WORD);
  endproperty
  a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");

  property p_evt_req;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (|req_i) |=> evt_status[EVT_REQ];
  endproperty
  a_evt_req: assert property (p_evt_req) else $error("request event not set");

  property p_irq_level;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      irq_o == (|(evt_status & evt_mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule : irq_flag_enable_priority_regs

//--- irq_core_model.sv
// Purpose: Core side model taking forwarded interrupt requests
// Assumes: pending and irq are synchronous to the system clock
// Notes: Registers what it sees, one cycle late
`timescale 1ns/1ps
module irq_core_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [31:0] pending_i,
  input wire logic irq_i,
  output logic [31:0] taken_o,
  output logic irq_seen_o
);
  // ==========================================================
  // Sample forwarded sources and the interrupt level
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      taken_o <= 32'h00000000;
      irq_seen_o <= 1'b0;
    end else begin
      taken_o <= pending_i;
      irq_seen_o <= irq_i;
    end
  end
endmodule : irq_core_model

//--- test_interrupt_flag_enable_priority_regs.sv
// Purpose: Self-checking bench for the flag, enable and priority registers
// Assumes: One-cycle registered ack, pending one cycle after state
// Notes: Core model watches pending and irq
`timescale 1ns/1ps
module test_interrupt_flag_enable_priority_regs;
  import irq_regs_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000, req = 32'h00000000;
  logic [31:0] rdat, pend, taken, q;
  logic ack, irq, irq_seen;
  int bad_count = 0, cmp_count = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  irq_flag_enable_priority_regs uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_i(req),
    .pending_o(pend), .irq_o(irq));
  irq_core_model core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pending_i(pend),
    .irq_i(irq), .taken_o(taken), .irq_seen_o(irq_seen));
  // ==========================================================
  // Verdict
  task finish_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ==========================================================
  // Wishbone classic access
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      finish_test();
    end
  endtask : acc
  task wait3;
    repeat (3) @(posedge clk_sys_i);
  endtask : wait3
  // ==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    acc(1'h0, OFS_FLAGS, 32'h0, 4'hf, q);
    chk("flags", 32'h00000000, q);
    acc(1'h0, OFS_ENABLES, 32'h0, 4'hf, q);
    chk("enables", 32'h00000000, q);
    acc(1'h0, OFS_PRIO_BASE, 32'h0, 4'hf, q);
    chk("prio", 32'h00000000, q);
    acc(1'h1, OFS_FLAGS, 32'ha5a5a5a5, 4'hf, q);
    acc(1'h0, OFS_FLAGS, 32'h0, 4'hf, q);
    chk("flags", 32'ha5a5a5a5, q);
    acc(1'h1, OFS_FLAGS, 32'h0, 4'hf, q);
    acc(1'h0, OFS_FLAGS, 32'h0, 4'hf, q);
    chk("flags", 32'h00000000, q);
    acc(1'h1, OFS_EVT_MASK, 32'h00000003, 4'hf, q);
    @(posedge clk_sys_i) req <= 32'h00000008;
    @(posedge clk_sys_i) req <= 32'h00000000;
    acc(1'h0, OFS_FLAGS, 32'h0, 4'hf, q);
    chk("flags", 32'h00000008, q);
    chk("irq", 32'h00000001, {31'h0, irq_seen});
    acc(1'h1, OFS_EVT_STATUS, 32'h00000003, 4'hf, q);
    wait3();
    chk("irq", 32'h00000000, {31'h0, irq_seen});
    acc(1'h1, OFS_ENABLES, 32'hffffffff, 4'hf, q);
    acc(1'h0, OFS_ENABLES, 32'h0, 4'hf, q);
    chk("enables", 32'hffffffff, q);
    acc(1'h1, OFS_PRIO_BASE, 32'hffffffff, 4'hf, q);
    acc(1'h0, OFS_PRIO_BASE, 32'h0, 4'hf, q);
    chk("prio", 32'h1f1f1f1f, q);
    wait3();
    chk("pending", 32'h00000008, taken);
    acc(1'h1, OFS_PRIO_BASE, 32'h03000000, 4'h8, q);
    acc(1'h0, OFS_PRIO_BASE, 32'h0, 4'hf, q);
    chk("prio", 32'h031f1f1f, q);
    wait3();
    chk("pending", 32'h00000000, taken);
    acc(1'h1, OFS_PRIO_BASE, 32'h04000000, 4'h8, q);
    wait3();
    chk("pending", 32'h00000008, taken);
    acc(1'h0, OFS_PENDING, 32'h0, 4'hf, q);
    chk("pending_reg", 32'h00000008, q);
    acc(1'h1, OFS_ENABLES, 32'hfffffff7, 4'hf, q);
    wait3();
    chk("pending", 32'h00000000, taken);
    acc(1'h0, 8'h40, 32'h0, 4'hf, q);
    chk("unmapped", 32'h00000000, q);
    acc(1'h0, OFS_EVT_STATUS, 32'h0, 4'hf, q);
    chk("status", 32'h00000002, q);
    chk("irq", 32'h00000001, {31'h0, irq_seen});
    acc(1'h1, OFS_EVT_MASK, 32'h00000001, 4'hf, q);
    wait3();
    chk("irq", 32'h00000000, {31'h0, irq_seen});
    finish_test();
  end
endmodule : test_interrupt_flag_enable_priority_regs
